/* File: design/rpt_pkg.sv */
package rpt_pkg;

	////////////////////////////////////////////////////////////////////////
	// opcode encodings (9-bit instruction words)
	localparam logic [8:0] OPC_SWAP_ACC_BASE  = 9'h060; // low 2 bits = j
	localparam logic [8:0] OPC_LOAD_ACC_BASE  = 9'h064; // low 2 bits = j
	localparam logic [8:0] OPC_SWAP_INC_BASE  = 9'h068; // low 2 bits = j
	localparam logic [8:0] OPC_SWAP_DEC_BASE  = 9'h06C; // low 2 bits = j
	localparam logic [8:0] OPC_DEC_Y          = 9'h017;
	localparam logic [8:0] OPC_INC_Y          = 9'h013;
	localparam logic [8:0] OPC_ACC_TO_PAGE    = 9'h029;
	localparam logic [8:0] OPC_E_TO_PAIR      = 9'h01A;
	localparam logic [8:0] OPC_PAIR_TO_E      = 9'h02A;
	localparam logic [8:0] OPC_ACC_TO_Y       = 9'h01F;
	localparam logic [8:0] OPC_Y_TO_ACC       = 9'h00C;
	localparam logic [8:0] OPC_PTR_LOAD_BASE  = 9'h0C0; // x in 5:4, y in 3:0

	////////////////////////////////////////////////////////////////////////
	// field positions inside the instruction word
	localparam int IMM_J_LSB = 0;
	localparam int IMM_Y_LSB = 0;
	localparam int IMM_X_LSB = 4;

	////////////////////////////////////////////////////////////////////////
	// pointer wrap values and memory shape
	localparam logic [3:0] Y_WRAP_UP   = 4'h0; // after increment
	localparam logic [3:0] Y_WRAP_DOWN = 4'hF; // after decrement
	localparam int         RAM_AW      = 6;    // {x, y}
	localparam int         RAM_DEPTH   = 64;

	////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic [3:0] RST_NIBBLE = 4'h0;
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [2:0] RST_PAGE   = 3'h0;
	localparam logic [1:0] RST_X      = 2'h0;

	// decoded operation classes
	typedef enum logic [3:0] {
		OP_OTHER,
		OP_SWAP_MEM_ACC,
		OP_LOAD_ACC_FROM_MEM,
		OP_SWAP_MEM_INC_Y,
		OP_SWAP_MEM_DEC_Y,
		OP_DECREMENT_Y_PTR,
		OP_INCREMENT_Y_PTR,
		OP_LOAD_POINTER_IMMEDIATE,
		OP_ACC_TO_TABLE_PAGE,
		OP_E_TO_ACC_PAIR,
		OP_ACC_PAIR_TO_E,
		OP_ACC_TO_Y_PTR,
		OP_Y_PTR_TO_ACC
	} rpt_op_t;

	// sequencer states, gray along idle -> memory -> idle
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MEM  = 2'b01
	} rpt_state_t;

endpackage

/* File: design/rpt_dec_if.sv */
`timescale 1ns/1ps
// carries an instruction word to the decoder and its fields back
interface rpt_dec_if;
	import rpt_pkg::*;
	logic [8:0] opcode; // raw instruction word
	rpt_op_t    op;     // decoded class
	logic [1:0] imm_j;  // pointer x xor value
	logic [1:0] imm_x;  // immediate x
	logic [3:0] imm_y;  // immediate y

	modport dec  (input opcode, output op, imm_j, imm_x, imm_y);
	modport core (output opcode, input op, imm_j, imm_x, imm_y);
endinterface // rpt_dec_if

/* File: design/rpt_decode.sv */
`timescale 1ns/1ps
module rpt_decode import rpt_pkg::*; (
	// decode channel
	rpt_dec_if.dec bus
);

	////////////////////////////////////////////////////////////////////////
	// immediate fields, valid only for the classes that use them
	assign bus.imm_j = bus.opcode[IMM_J_LSB +: 2];
	assign bus.imm_x = bus.opcode[IMM_X_LSB +: 2];
	assign bus.imm_y = bus.opcode[IMM_Y_LSB +: 4];

	// class decode; unknown words fall to other so they change nothing here but end a pointer-load run
	always_comb begin
		if (bus.opcode[8:2] == OPC_SWAP_ACC_BASE[8:2]) begin
			bus.op = OP_SWAP_MEM_ACC;
		end else if (bus.opcode[8:2] == OPC_LOAD_ACC_BASE[8:2]) begin
			bus.op = OP_LOAD_ACC_FROM_MEM;
		end else if (bus.opcode[8:2] == OPC_SWAP_INC_BASE[8:2]) begin
			bus.op = OP_SWAP_MEM_INC_Y;
		end else if (bus.opcode[8:2] == OPC_SWAP_DEC_BASE[8:2]) begin
			bus.op = OP_SWAP_MEM_DEC_Y;
		end else if (bus.opcode[8:6] == OPC_PTR_LOAD_BASE[8:6]) begin
			bus.op = OP_LOAD_POINTER_IMMEDIATE;
		end else begin
			case (bus.opcode)
				OPC_DEC_Y:       bus.op = OP_DECREMENT_Y_PTR;
				OPC_INC_Y:       bus.op = OP_INCREMENT_Y_PTR;
				OPC_ACC_TO_PAGE: bus.op = OP_ACC_TO_TABLE_PAGE;
				OPC_E_TO_PAIR:   bus.op = OP_E_TO_ACC_PAIR;
				OPC_PAIR_TO_E:   bus.op = OP_ACC_PAIR_TO_E;
				OPC_ACC_TO_Y:    bus.op = OP_ACC_TO_Y_PTR;
				OPC_Y_TO_ACC:    bus.op = OP_Y_PTR_TO_ACC;
				default:         bus.op = OP_OTHER;
			endcase
		end
	end

endmodule // rpt_decode

/* File: design/rpt_ram.sv */
`timescale 1ns/1ps
module rpt_ram import rpt_pkg::*; (
	// clock
	input  wire logic              i_clock,
	// write side
	input  wire logic              i_we,
	input  wire logic [RAM_AW-1:0] i_waddr,
	input  wire logic [3:0]        i_wdata,
	// read side, data one cycle after the address
	input  wire logic [RAM_AW-1:0] i_raddr,
	output logic      [3:0]        o_rdata
);

	logic [3:0] mem [RAM_DEPTH]; // data nibbles, not reset (backed-up data)

	////////////////////////////////////////////////////////////////////////
	// read before write: a same-cycle write is not seen until next read
	always_ff @(posedge i_clock) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end

endmodule // rpt_ram

/* File: design/rpt_core.sv */
`timescale 1ns/1ps
// Function
// - swap, xor x, increment y, skip on 0
// - swap, xor x, decrement y, skip on 15
// - swap nibble with acc, xor x only
// - load acc from nibble, xor x
// - decrement y, skip when 15
// - increment y, skip when 0
// - immediate load of x and y
// - only first of consecutive pointer loads runs
// - acc copied to table page register
// - e copied into acc and b
// - b and acc loaded into e
// - acc copied into y, no skip
// - y copied into acc, y kept
// - b holds e high, acc e low
// - page gets low three acc bits
module rpt_core import rpt_pkg::*; (
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_resetn,
	// instruction stream from the fetch logic
	input  wire logic       i_instr_valid,
	input  wire logic [8:0] i_opcode,
	// instruction handshake
	output logic            o_instr_ready,
	output logic            o_instr_done,
	output logic            o_skipped,
	output logic            o_skip_next,
	// architectural registers
	output logic      [3:0] o_acc,
	output logic      [3:0] o_reg_b,
	output logic      [7:0] o_reg_e,
	output logic      [2:0] o_table_page,
	output logic      [1:0] o_ptr_x,
	output logic      [3:0] o_ptr_y
);

	////////////////////////////////////////////////////////////////////////
	// state
	rpt_state_t state, next_state;       // sequencer
	rpt_op_t    op_q, next_op_q;         // memory op held for second cycle
	logic [1:0] j_q, next_j_q;           // its xor value
	logic       lxy_run, next_lxy_run;   // last fetched was pointer load
	logic       next_ready;
	logic       next_done;
	logic       next_skipped;
	logic       next_skip;
	logic [3:0] next_acc;
	logic [3:0] next_b;
	logic [7:0] next_e;
	logic [2:0] next_page;
	logic [1:0] next_x;
	logic [3:0] next_y;

	// memory port
	logic       ram_we;                  // write back in memory cycle
	logic [3:0] ram_rdata;               // nibble at ram_pointer
	logic [RAM_AW-1:0] ram_pointer;      // {x, y}

	// acceptance terms
	logic       fetch;                   // an instruction is taken
	logic       drop;                    // taken but skipped
	logic       take;                    // taken and executed

	rpt_dec_if dec ();

	////////////////////////////////////////////////////////////////////////
	// decoder and data memory
	assign dec.opcode  = i_opcode;
	assign ram_pointer = {o_ptr_x, o_ptr_y};

	rpt_decode u_decode (
		.bus (dec.dec)
	);

	rpt_ram u_ram (
		.i_clock (i_clock),
		.i_we    (ram_we),
		.i_waddr (ram_pointer),
		.i_wdata (o_acc),
		.i_raddr (ram_pointer),
		.o_rdata (ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// acceptance: a pending skip or a repeated pointer load drops the word
	assign fetch = (state == ST_IDLE) && i_instr_valid;
	assign drop  = o_skip_next ||
		(lxy_run && dec.op == OP_LOAD_POINTER_IMMEDIATE);
	assign take  = fetch && !drop;

	////////////////////////////////////////////////////////////////////////
	// next-value logic for sequencer and registers
	always_comb begin
		next_state   = state;
		next_op_q    = op_q;
		next_j_q     = j_q;
		next_lxy_run = lxy_run;
		next_done    = 1'b0;
		next_skipped = 1'b0;
		next_skip    = o_skip_next;
		next_acc     = o_acc;
		next_b       = o_reg_b;
		next_e       = o_reg_e;
		next_page    = o_table_page;
		next_x       = o_ptr_x;
		next_y       = o_ptr_y;
		ram_we       = 1'b0;
		case (state)
			ST_IDLE: begin
				if (fetch) begin
					// run tracking counts skipped loads too
					next_lxy_run = (dec.op == OP_LOAD_POINTER_IMMEDIATE);
					next_done    = 1'b1;
				end
				if (fetch && drop) begin
					// slot is used but nothing else moves
					next_skip    = 1'b0;
					next_skipped = 1'b1;
				end else if (take) begin
					case (dec.op)
						OP_SWAP_MEM_ACC, OP_LOAD_ACC_FROM_MEM,
						OP_SWAP_MEM_INC_Y, OP_SWAP_MEM_DEC_Y: begin
							// read data arrives next cycle
							next_state = ST_MEM;
							next_op_q  = dec.op;
							next_j_q   = dec.imm_j;
							next_done  = 1'b0;
						end
						OP_DECREMENT_Y_PTR: begin
							next_y    = o_ptr_y - 4'h1;
							next_skip = (next_y == Y_WRAP_DOWN);
						end
						OP_INCREMENT_Y_PTR: begin
							next_y    = o_ptr_y + 4'h1;
							next_skip = (next_y == Y_WRAP_UP);
						end
						OP_LOAD_POINTER_IMMEDIATE: begin
							next_x = dec.imm_x;
							next_y = dec.imm_y;
						end
						OP_ACC_TO_TABLE_PAGE: begin
							next_page = o_acc[2:0];
						end
						OP_E_TO_ACC_PAIR: begin
							next_b   = o_reg_e[7:4];
							next_acc = o_reg_e[3:0];
						end
						OP_ACC_PAIR_TO_E: begin
							next_e = {o_reg_b, o_acc};
						end
						OP_ACC_TO_Y_PTR: begin
							next_y = o_acc;
						end
						OP_Y_PTR_TO_ACC: begin
							next_acc = o_ptr_y;
						end
						default: begin
							// other classes belong to other units
						end
					endcase
				end
			end
			ST_MEM: begin
				// second cycle: exchange or load, then pointer update
				next_state = ST_IDLE;
				next_done  = 1'b1;
				next_acc   = ram_rdata;
				next_x     = o_ptr_x ^ j_q;
				ram_we     = (op_q != OP_LOAD_ACC_FROM_MEM);
				case (op_q)
					OP_SWAP_MEM_INC_Y: begin
						next_y    = o_ptr_y + 4'h1;
						next_skip = (next_y == Y_WRAP_UP);
					end
					OP_SWAP_MEM_DEC_Y: begin
						next_y    = o_ptr_y - 4'h1;
						next_skip = (next_y == Y_WRAP_DOWN);
					end
					default: begin
						// y and skip left alone
					end
				endcase
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_ready = (next_state == ST_IDLE);
	end

	////////////////////////////////////////////////////////////////////////
	// registers; the pointer stays put between cycles of a memory op
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state         <= ST_IDLE;
			op_q          <= OP_OTHER;
			j_q           <= RST_X;
			lxy_run       <= 1'b0;
			o_instr_ready <= 1'b1;
			o_instr_done  <= 1'b0;
			o_skipped     <= 1'b0;
			o_skip_next   <= 1'b0;
			o_acc         <= RST_NIBBLE;
			o_reg_b       <= RST_NIBBLE;
			o_reg_e       <= RST_BYTE;
			o_table_page  <= RST_PAGE;
			o_ptr_x       <= RST_X;
			o_ptr_y       <= RST_NIBBLE;
		end else begin
			state         <= next_state;
			op_q          <= next_op_q;
			j_q           <= next_j_q;
			lxy_run       <= next_lxy_run;
			o_instr_ready <= next_ready;
			o_instr_done  <= next_done;
			o_skipped     <= next_skipped;
			o_skip_next   <= next_skip;
			o_acc         <= next_acc;
			o_reg_b       <= next_b;
			o_reg_e       <= next_e;
			o_table_page  <= next_page;
			o_ptr_x       <= next_x;
			o_ptr_y       <= next_y;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	sequence s_mem_start(rpt_op_t k);
		take && dec.op == k;
	endsequence

	sequence s_mem_done;
		state == ST_MEM ##1 o_instr_done && state == ST_IDLE;
	endsequence

	AST_SWAP_INC: assert property (s_mem_start(OP_SWAP_MEM_INC_Y)
		|=> s_mem_done and ##1 (o_ptr_y == $past(o_ptr_y, 2) + 4'h1
		&& o_skip_next == (o_ptr_y == Y_WRAP_UP)
		&& o_ptr_x == ($past(o_ptr_x, 2) ^ $past(dec.imm_j, 2))))
		else $error("increment exchange wrong");
	AST_SWAP_DEC: assert property (s_mem_start(OP_SWAP_MEM_DEC_Y)
		|=> s_mem_done and ##1 (o_ptr_y == $past(o_ptr_y, 2) - 4'h1
		&& o_skip_next == (o_ptr_y == Y_WRAP_DOWN)))
		else $error("decrement exchange wrong");
	AST_SWAP_ACC: assert property (s_mem_start(OP_SWAP_MEM_ACC)
		|=> s_mem_done and ##1 (o_acc == $past(ram_rdata)
		&& o_ptr_y == $past(o_ptr_y, 2) && !o_skip_next
		&& o_ptr_x == ($past(o_ptr_x, 2) ^ $past(dec.imm_j, 2))))
		else $error("plain exchange wrong");
	AST_LOAD_ACC: assert property (state == ST_MEM
		&& op_q == OP_LOAD_ACC_FROM_MEM |-> !ram_we ##1 o_acc == $past(ram_rdata))
		else $error("memory load wrote memory or missed acc");
	AST_DEC_Y: assert property (take && dec.op == OP_DECREMENT_Y_PTR
		|=> o_ptr_y == $past(o_ptr_y) - 4'h1
		&& o_skip_next == ($past(o_ptr_y) == 4'h0))
		else $error("y decrement wrong");
	AST_INC_Y: assert property (take && dec.op == OP_INCREMENT_Y_PTR
		|=> o_ptr_y == $past(o_ptr_y) + 4'h1
		&& o_skip_next == ($past(o_ptr_y) == 4'hF))
		else $error("y increment wrong");
	AST_PTR_LOAD: assert property (take
		&& dec.op == OP_LOAD_POINTER_IMMEDIATE
		|=> o_ptr_x == $past(dec.imm_x) && o_ptr_y == $past(dec.imm_y))
		else $error("pointer load wrong");
	AST_PTR_RUN: assert property (fetch
		&& dec.op == OP_LOAD_POINTER_IMMEDIATE
		##1 fetch && dec.op == OP_LOAD_POINTER_IMMEDIATE
		|=> o_skipped && $stable(o_ptr_x) && $stable(o_ptr_y))
		else $error("second pointer load executed");
	AST_PAGE: assert property (take && dec.op == OP_ACC_TO_TABLE_PAGE
		|=> o_table_page == $past(o_acc[2:0]))
		else $error("page transfer wrong");
	AST_E_SPLIT: assert property (take && dec.op == OP_E_TO_ACC_PAIR
		|=> o_reg_b == $past(o_reg_e[7:4]) && o_acc == $past(o_reg_e[3:0]))
		else $error("e split wrong"); // too
	AST_E_JOIN: assert property (take && dec.op == OP_ACC_PAIR_TO_E
		|=> o_reg_e == {$past(o_reg_b), $past(o_acc)})
		else $error("e join wrong");
	AST_ACC_Y: assert property (take && dec.op == OP_ACC_TO_Y_PTR
		|=> o_ptr_y == $past(o_acc) && $stable(o_acc) && !o_skip_next)
		else $error("acc to y wrong");
	AST_Y_ACC: assert property (take && dec.op == OP_Y_PTR_TO_ACC
		|=> o_acc == $past(o_ptr_y) && $stable(o_ptr_y))
		else $error("y to acc wrong");
	AST_SKIP: assert property (fetch && o_skip_next
		|=> o_instr_done && o_skipped && !o_skip_next && $stable(o_acc)
		&& $stable(o_reg_e) && $stable(o_ptr_y) && state == ST_IDLE)
		else $error("skipped instruction changed state");

endmodule // rpt_core

/* File: tb/ram_pointer_transfer_unit_bench.sv */
`timescale 1ns/1ps
module ram_pointer_transfer_unit_bench import rpt_pkg::*;;
	// design stimulus and observation
	logic       i_clock;
	logic       i_resetn;
	logic       i_instr_valid;
	logic [8:0] i_opcode;
	logic       o_instr_ready;
	logic       o_instr_done;
	logic       o_skipped;
	logic       o_skip_next;
	logic [3:0] o_acc;
	logic [3:0] o_reg_b;
	logic [7:0] o_reg_e;
	logic [2:0] o_table_page;
	logic [1:0] o_ptr_x;
	logic [3:0] o_ptr_y;
	// bench model of the architectural state
	logic [3:0] m_acc, m_b, m_y;
	logic [7:0] m_e;
	logic [2:0] m_page;
	logic [1:0] m_x;
	logic       m_skip, m_run;
	logic [3:0] m_mem [64]; // unwritten cells stay unknown
	// bookkeeping
	int         num_errors;
	int         checks;
	int         cycles;

	////////////////////////////////////////////////////////////////////////
	rpt_core dut_u (
		.i_clock       (i_clock),
		.i_resetn      (i_resetn),
		.i_instr_valid (i_instr_valid),
		.i_opcode      (i_opcode),
		.o_instr_ready (o_instr_ready),
		.o_instr_done  (o_instr_done),
		.o_skipped     (o_skipped),
		.o_skip_next   (o_skip_next),
		.o_acc         (o_acc),
		.o_reg_b       (o_reg_b),
		.o_reg_e       (o_reg_e),
		.o_table_page  (o_table_page),
		.o_ptr_x       (o_ptr_x),
		.o_ptr_y       (o_ptr_y)
	);

	// 200 MHz clock
	always #2.5 i_clock = ~i_clock;

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (num_errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one comparison, values widened to a byte
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask

	// all visible state against the model
	task automatic chk_state();
		if (!$isunknown(m_acc)) begin
			chk("acc", {4'h0, m_acc}, {4'h0, o_acc});
		end
		chk("reg_b", {4'h0, m_b}, {4'h0, o_reg_b});
		chk("reg_e", m_e, o_reg_e);
		chk("page", {5'h00, m_page}, {5'h00, o_table_page});
		chk("ptr_x", {6'h00, m_x}, {6'h00, o_ptr_x});
		chk("ptr_y", {4'h0, m_y}, {4'h0, o_ptr_y});
		chk("skip_next", {7'h00, m_skip}, {7'h00, o_skip_next});
	endtask

	////////////////////////////////////////////////////////////////////////
	// issue one word, update the model, judge latency and state
	task automatic exec(input logic [8:0] op);
		logic       load_pointer_immediate, skp, memop;
		logic [3:0] t;
		int         lat;
		load_pointer_immediate = (op[8:6] == 3'b011);
		skp = m_skip || (load_pointer_immediate && m_run);
		memop = 1'b0;
		lat = 0;
		@(negedge i_clock);
		chk("ready", 8'h01, {7'h00, o_instr_ready});
		i_instr_valid = 1'b1;
		i_opcode = op;
		// a skipped word leaves every register but the skip and run flags alone
		m_run = load_pointer_immediate;
		m_skip = 1'b0;
		if (!skp && op[8:4] == 5'h06) begin
			memop = 1'b1;
			t = m_mem[{m_x, m_y}];
			if (op[3:2] != 2'b01) begin
				m_mem[{m_x, m_y}] = m_acc;
			end
			m_acc = t;
			m_x = m_x ^ op[1:0];
			if (op[3:2] == 2'b10) begin
				m_y = m_y + 4'h1;
				m_skip = (m_y == Y_WRAP_UP);
			end
			if (op[3:2] == 2'b11) begin
				m_y = m_y - 4'h1;
				m_skip = (m_y == Y_WRAP_DOWN);
			end
		end else if (!skp && load_pointer_immediate) begin
			m_x = op[5:4];
			m_y = op[3:0];
		end else if (!skp) begin
			case (op)
				OPC_DEC_Y: begin
					m_y = m_y - 4'h1;
					m_skip = (m_y == Y_WRAP_DOWN);
				end
				OPC_INC_Y: begin
					m_y = m_y + 4'h1;
					m_skip = (m_y == Y_WRAP_UP);
				end
				OPC_ACC_TO_PAGE: m_page = m_acc[2:0];
				OPC_E_TO_PAIR:   {m_b, m_acc} = m_e;
				OPC_PAIR_TO_E:   m_e = {m_b, m_acc};
				OPC_ACC_TO_Y:    m_y = m_acc;
				OPC_Y_TO_ACC:    m_acc = m_y;
				default: ;
			endcase
		end
		@(posedge i_clock);
		// bounded wait for the completion pulse
		for (int k = 1; k <= 4; k++) begin
			@(negedge i_clock);
			if (k == 1) begin
				i_instr_valid = 1'b0;
			end
			if (o_instr_done === 1'b1 && lat == 0) begin
				lat = k;
				chk("skipped", {7'h00, skp}, {7'h00, o_skipped});
				chk_state();
			end
		end
		chk("latency", (memop ? 8'h02 : 8'h01), 8'(lat));
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		@(negedge i_clock);
		chk("ready", 8'h01, {7'h00, o_instr_ready});
		chk("done", 8'h00, {7'h00, o_instr_done});
		chk_state();
	endtask

	// pointer loads in a run, an unknown word breaks the run
	task automatic t_ptr_run();
		exec(OPC_PTR_LOAD_BASE | 9'h023);
		exec(OPC_PTR_LOAD_BASE | 9'h017);
		exec(OPC_PTR_LOAD_BASE | 9'h033);
		exec(OPC_Y_TO_ACC);
		exec(OPC_PTR_LOAD_BASE | 9'h01E);
		exec(9'h000);
		exec(OPC_PTR_LOAD_BASE | 9'h03C);
	endtask

	// y wrap in both directions and the skip that follows
	task automatic t_inc_dec();
		exec(OPC_Y_TO_ACC);
		exec(OPC_PTR_LOAD_BASE | 9'h00E);
		exec(OPC_INC_Y);
		exec(OPC_INC_Y);
		exec(OPC_ACC_TO_Y);
		exec(OPC_DEC_Y);
		exec(OPC_PTR_LOAD_BASE | 9'h021);
		exec(OPC_PTR_LOAD_BASE | 9'h022);
		exec(OPC_DEC_Y);
	endtask

	// memory swaps and loads with x update; a cell is first touched by
	// an exchange that neither wraps nor is checked on acc, and acc is
	// reloaded at once, so no unknown nibble reaches a later check
	task automatic t_mem();
		exec(OPC_PTR_LOAD_BASE | 9'h02E);
		exec(OPC_SWAP_INC_BASE | 9'h000);
		exec(OPC_Y_TO_ACC);
		exec(OPC_SWAP_DEC_BASE | 9'h000);
		exec(OPC_Y_TO_ACC);
		exec(OPC_PTR_LOAD_BASE | 9'h02F);
		exec(OPC_SWAP_INC_BASE | 9'h003);
		exec(OPC_Y_TO_ACC);
		exec(OPC_PTR_LOAD_BASE | 9'h020);
		exec(OPC_SWAP_INC_BASE | 9'h000);
		exec(OPC_Y_TO_ACC);
		exec(OPC_PTR_LOAD_BASE | 9'h020);
		exec(OPC_SWAP_DEC_BASE | 9'h002);
		exec(OPC_LOAD_ACC_BASE | 9'h000);
		exec(OPC_PTR_LOAD_BASE | 9'h02E);
		exec(OPC_LOAD_ACC_BASE | 9'h001);
		exec(OPC_PTR_LOAD_BASE | 9'h02F);
		exec(OPC_LOAD_ACC_BASE | 9'h000);
		exec(OPC_PTR_LOAD_BASE | 9'h02E);
		exec(OPC_Y_TO_ACC);
		exec(OPC_SWAP_ACC_BASE | 9'h003);
		exec(OPC_PTR_LOAD_BASE | 9'h02E);
		exec(OPC_LOAD_ACC_BASE | 9'h000);
	endtask

	// back-to-back pointer loads: the second is dropped on the next edge
	task automatic t_burst();
		@(negedge i_clock);
		i_instr_valid = 1'b1;
		i_opcode = OPC_PTR_LOAD_BASE | 9'h012;
		@(negedge i_clock);
		chk("done", 8'h01, {7'h00, o_instr_done});
		chk("skipped", 8'h00, {7'h00, o_skipped});
		i_opcode = OPC_PTR_LOAD_BASE | 9'h035;
		@(negedge i_clock);
		i_instr_valid = 1'b0;
		m_x = 2'h1;
		m_y = 4'h2;
		m_run = 1'b1;
		chk("done", 8'h01, {7'h00, o_instr_done});
		chk("skipped", 8'h01, {7'h00, o_skipped});
		chk_state();
	endtask

	// register transfers, page gets three bits only
	task automatic t_xfer();
		exec(OPC_PTR_LOAD_BASE | 9'h00D);
		exec(OPC_Y_TO_ACC);
		exec(OPC_ACC_TO_PAGE);
		exec(OPC_PAIR_TO_E);
		exec(OPC_PTR_LOAD_BASE | 9'h030);
		exec(OPC_Y_TO_ACC);
		exec(OPC_ACC_TO_Y);
		exec(OPC_E_TO_PAIR);
		exec(OPC_ACC_TO_Y);
		exec(OPC_DEC_Y);
		exec(OPC_ACC_TO_Y);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		i_clock = 1'b0;
		i_resetn = 1'b0;
		i_instr_valid = 1'b0;
		i_opcode = 9'h000;
		{m_acc, m_b, m_y, m_e, m_page, m_x} = '0;
		m_skip = 1'b0;
		m_run = 1'b0;
		num_errors = 0;
		checks = 0;
		cycles = 0;
		repeat (3) @(posedge i_clock);
		@(negedge i_clock);
		i_resetn = 1'b1;
		t_reset();
		t_ptr_run();
		t_inc_dec();
		t_mem();
		t_xfer();
		t_burst();
		tally_and_finish();
	end
endmodule // ram_pointer_transfer_unit_bench
